// File: auth_pkg.sv
// Purpose: shared constants, carriers and crc helpers for the single-wire session control
// Assumes: 25 MHz device clock, token decoding done outside this block
// Notes: interval figures are plain defaults, the top-level parameters override them
package auth_pkg;

    // =========================================
    // clock and intervals
    localparam int CLK_PERIOD_NS = 40;
    localparam int BLOCK_CHECK_DELAY_NS = 100000;
    localparam int COMMAND_RUN_DELAY_NS = 13000000;
    localparam int TOKEN_GAP_LIMIT_NS = 1500000;
    localparam int WATCHDOG_NS = 1000000000;
    localparam int WAKE_LOW_TIME_NS = 60000;
    localparam int WAKE_HIGH_TIME_NS = 2500000;
    localparam int BLOCK_CHECK_CYC = BLOCK_CHECK_DELAY_NS / CLK_PERIOD_NS;
    localparam int COMMAND_RUN_CYC = COMMAND_RUN_DELAY_NS / CLK_PERIOD_NS;
    localparam int TOKEN_GAP_CYC = TOKEN_GAP_LIMIT_NS / CLK_PERIOD_NS;
    localparam int WATCHDOG_CYC = WATCHDOG_NS / CLK_PERIOD_NS;
    localparam int WAKE_CYC = (WAKE_LOW_TIME_NS + WAKE_HIGH_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;

    // =========================================
    // flags, status codes, block framing
    localparam logic [7:0] FLAG_COMMAND = 8'h66;
    localparam logic [7:0] FLAG_TRANSMIT = 8'h99;
    localparam logic [7:0] FLAG_SLEEP = 8'hCC;
    localparam logic [7:0] STAT_WAKE = 8'h11;
    localparam logic [7:0] STAT_COMM_ERR = 8'hFF;
    localparam logic [7:0] STAT_EXEC_ERR = 8'h0F;
    localparam logic [7:0] COUNT_MIN = 8'h04;
    localparam logic [7:0] COUNT_MAX = 8'h27;
    localparam logic [7:0] RESP_COUNT = 8'h04;
    localparam logic [2:0] RESP_LAST = 3'h4;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;

    // =========================================
    // carriers
    typedef struct packed {
        logic lead;
        logic done;
        logic value;
        logic bad;
    } auth_tok_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } auth_byte_t;

    // =========================================
    // crc helpers, bits taken lsb first
    function automatic logic [15:0] auth_crc_bit(input logic [15:0] crc, input logic b);
        logic fb;
        fb = b ^ crc[15];
        return {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    endfunction

    function automatic logic [15:0] auth_crc_byte(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            c = auth_crc_bit(c, d[i]);
        end
        return c;
    endfunction

endpackage

// File: auth_buf2.sv
// Purpose: two-entry valid/ready buffer on the reply path
// Assumes: single clock, flush empties both entries
// Notes: out_data comes straight from an entry register
`timescale 1ns/1ps
module auth_buf2 #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    import auth_pkg::*;

    logic [WIDTH-1:0] mem_reg [2];
    logic [1:0] cnt_reg;
    logic wr_reg;
    logic rd_reg;
    logic push;
    logic pop;

    assign in_ready = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // =========================================
    // storage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    // =========================================
    // pointers and fill count
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 2'h0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else if (flush) begin
            cnt_reg <= 2'h0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_reg <= ~wr_reg;
            end
            if (pop) begin
                rd_reg <= ~rd_reg;
            end
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

// File: auth_io_ctrl.sv
// Purpose: session, framing, timeout and watchdog control of the single-wire link
// Assumes: tokens arrive decoded and on this clock; replies leave as bytes
// Notes: the byte transmitter sends each reply byte lsb first
`timescale 1ns/1ps
// Function
// [RULE_01] sleep flag enters low power, resets engine and buffer; accepted like any flag
// [RULE_02] system splits sessions longer than the watchdog interval with sleep and wake
// [RULE_03] block opens with count byte, legal counts 4 to 39 inclusive
// [RULE_04] block ends with crc-16, poly 0x8005, start zero, must match
// [RULE_05] crc goes out low byte first, high byte last
// [RULE_06] wake then transmit flag returns status 0x11
// [RULE_07] after block and parse delay: malformed gives error block, good ignores flag
// [RULE_08] after execution, transmit flag returns output block, may be re-fetched
// [RULE_09] system may wait parse plus execution delay for short commands
// [RULE_10] incomplete token leads to sleep when the token gap limit expires
// [RULE_11] low pulse over zero_low_max is illegal, sleep after gap limit
// [RULE_12] timeout armed through command block, restarted by every legal token
// [RULE_13] timeout armed at wake, no first token means back to sleep
// [RULE_14] timeout disabled while executing a command
// [RULE_15] system resynchronises by waiting, waking, fetching status 0x11
// [RULE_16] failed resynchronisation: system waits twice the gap limit, wakes again
// [RULE_17] token while asleep is a wake; tokens during wake delay ignored
// [RULE_18] no external reset; watchdog expiry clears errors, system idles then wakes
// [RULE_19] watchdog starts at wake and forces sleep on expiry, even mid-command
// [RULE_20] watchdog cleared only by sleep and a fresh wake
// [RULE_21] bytes travel lsb first, multi-byte fields kept in received order
// [RULE_22] flags 0x66 command, 0x99 transmit, 0xCC sleep precede every transaction
// [RULE_23] any other flag value is ignored silently
// [RULE_24] status replies are four-byte blocks; 0xFF comm error, 0x0F execution error
// [RULE_25] all intervals are parameterised cycle counts of the device clock
module auth_io_ctrl
    import auth_pkg::*;
#(
    parameter int BLOCK_CHECK_CYCLES = auth_pkg::BLOCK_CHECK_CYC,
    parameter int COMMAND_RUN_CYCLES = auth_pkg::COMMAND_RUN_CYC,
    parameter int TOKEN_GAP_CYCLES = auth_pkg::TOKEN_GAP_CYC,
    parameter int WATCHDOG_CYCLES = auth_pkg::WATCHDOG_CYC,
    parameter int WAKE_CYCLES = auth_pkg::WAKE_CYC // [RULE_25]
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire auth_pkg::auth_tok_t tok,
    output auth_pkg::auth_byte_t rx_byte,
    output logic exec_start,
    input wire logic exec_done,
    input wire logic exec_err,
    input wire logic [7:0] exec_result,
    output logic eng_rst,
    output logic low_power,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready
);
    import auth_pkg::*;

    typedef enum logic [2:0] {
        ST_SLEEP, ST_WAKE, ST_IDLE, ST_CMD, ST_PARSE, ST_EXEC, ST_TX
    } auth_state_t;

    auth_state_t state_reg;
    logic [31:0] dly_reg;
    logic [31:0] gap_reg;
    logic [31:0] wd_reg;
    logic [7:0] sh_reg;
    logic [2:0] bit_reg;
    logic [7:0] idx_reg;
    logic [7:0] count_reg;
    logic [15:0] crc_reg;
    logic bad_reg;
    logic [7:0] resp_reg;
    logic resp_ok_reg;
    logic done_seen_reg;
    logic [2:0] tx_idx_reg;
    auth_byte_t rx_reg;
    logic exec_start_reg;
    logic low_power_reg;
    logic listening;
    logic byte_done;
    logic [7:0] new_byte;
    logic gap_expire;
    logic wd_expire;
    logic go_sleep;
    logic count_bad;
    logic in_crc_zone;
    logic parse_end;
    logic exec_end;
    logic tx_end;
    logic [15:0] resp_crc;
    logic buf_in_valid;
    logic buf_in_ready;
    logic [7:0] buf_in_data;

    // =========================================
    // byte assembly and event decode
    assign listening = (state_reg == ST_IDLE) || (state_reg == ST_CMD);
    assign new_byte = {tok.value, sh_reg[7:1]}; // [RULE_21]
    assign byte_done = listening && tok.done && (bit_reg == BIT_LAST);
    assign gap_expire = listening && (gap_reg == 32'(TOKEN_GAP_CYCLES - 1));
    assign wd_expire = (state_reg != ST_SLEEP) && (wd_reg == 32'(WATCHDOG_CYCLES - 1));
    assign go_sleep = wd_expire || gap_expire // [RULE_19] [RULE_10] [RULE_13]
        || (state_reg == ST_IDLE && byte_done && new_byte == FLAG_SLEEP); // [RULE_01]
    assign count_bad = (new_byte < COUNT_MIN) || (new_byte > COUNT_MAX); // [RULE_03]
    assign in_crc_zone = (idx_reg == 8'h00) || (idx_reg < count_reg - 8'h02);
    assign parse_end = (state_reg == ST_PARSE) && (dly_reg == 32'(BLOCK_CHECK_CYCLES - 1));
    assign exec_end = (state_reg == ST_EXEC) && (dly_reg >= 32'(COMMAND_RUN_CYCLES - 1))
        && (done_seen_reg || exec_done);
    assign tx_end = (state_reg == ST_TX) && (tx_idx_reg == RESP_LAST) && !tx_valid;

    // =========================================
    // bit shifter
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sh_reg <= 8'h00;
            bit_reg <= 3'h0;
        end else if (!listening) begin
            bit_reg <= 3'h0;
        end else if (tok.done) begin
            sh_reg <= new_byte;
            bit_reg <= bit_reg + 3'h1;
        end
    end

    // =========================================
    // session state
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_SLEEP;
            dly_reg <= 32'h0000_0000;
        end else if (go_sleep && state_reg != ST_SLEEP) begin
            state_reg <= ST_SLEEP;
            dly_reg <= 32'h0000_0000;
        end else begin
            dly_reg <= dly_reg + 32'h0000_0001;
            case (state_reg)
                ST_SLEEP: begin
                    dly_reg <= 32'h0000_0000;
                    if (tok.lead || tok.done) begin
                        state_reg <= ST_WAKE; // [RULE_17]
                    end
                end
                ST_WAKE: begin
                    if (dly_reg == 32'(WAKE_CYCLES - 1)) begin
                        state_reg <= ST_IDLE; // [RULE_17]
                    end
                end
                ST_IDLE: begin // [RULE_23]
                    if (byte_done && new_byte == FLAG_COMMAND) begin
                        state_reg <= ST_CMD; // [RULE_22]
                    end else if (byte_done && new_byte == FLAG_TRANSMIT && resp_ok_reg) begin
                        state_reg <= ST_TX; // [RULE_06] [RULE_08]
                    end
                end
                ST_CMD: begin
                    dly_reg <= 32'h0000_0000;
                    if (byte_done && ((idx_reg == 8'h00 && count_bad)
                        || (idx_reg != 8'h00 && idx_reg == count_reg - 8'h01))) begin
                        state_reg <= ST_PARSE;
                    end
                end
                ST_PARSE: begin
                    if (parse_end) begin
                        state_reg <= bad_reg ? ST_IDLE : ST_EXEC; // [RULE_07]
                        dly_reg <= 32'h0000_0000;
                    end
                end
                ST_EXEC: begin
                    if (exec_end) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_TX: begin
                    if (tx_end) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_SLEEP;
                end
            endcase
        end
    end

    // =========================================
    // command block reception and check
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            idx_reg <= 8'h00;
            count_reg <= 8'h00;
            crc_reg <= CRC_INIT;
            bad_reg <= 1'b0;
        end else if (state_reg != ST_CMD) begin
            if (state_reg != ST_PARSE) begin
                idx_reg <= 8'h00;
                crc_reg <= CRC_INIT; // [RULE_04]
                bad_reg <= 1'b0;
            end
        end else begin
            if (tok.done && in_crc_zone) begin
                crc_reg <= auth_crc_bit(crc_reg, tok.value); // [RULE_04] [RULE_21]
            end
            if (byte_done) begin
                idx_reg <= idx_reg + 8'h01;
                if (idx_reg == 8'h00) begin
                    count_reg <= new_byte; // [RULE_03]
                    bad_reg <= count_bad; // [RULE_03]
                end else if (idx_reg == count_reg - 8'h02) begin
                    bad_reg <= bad_reg | (new_byte != crc_reg[7:0]); // [RULE_05]
                end else if (idx_reg == count_reg - 8'h01) begin
                    bad_reg <= bad_reg | (new_byte != crc_reg[15:8]); // [RULE_05]
                end
            end
        end
    end

    // =========================================
    // packet bytes to the command engine
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_reg <= '0;
            exec_start_reg <= 1'b0;
        end else begin
            rx_reg.valid <= (state_reg == ST_CMD) && byte_done && (idx_reg != 8'h00)
                && (idx_reg < count_reg - 8'h02); // [RULE_21]
            rx_reg.data <= new_byte;
            exec_start_reg <= parse_end && !bad_reg && !go_sleep; // [RULE_07]
        end
    end

    // =========================================
    // token gap timeout
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            gap_reg <= 32'h0000_0000;
        end else if (!listening) begin
            gap_reg <= 32'h0000_0000; // [RULE_14]
        end else if (tok.done && !tok.bad) begin
            gap_reg <= 32'h0000_0000; // [RULE_12]
        end else begin
            gap_reg <= gap_reg + 32'h0000_0001; // [RULE_10] [RULE_11] [RULE_13]
        end
    end

    // =========================================
    // watchdog
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wd_reg <= 32'h0000_0000;
        end else if (state_reg == ST_SLEEP) begin
            wd_reg <= 32'h0000_0000; // [RULE_20]
        end else begin
            wd_reg <= wd_reg + 32'h0000_0001; // [RULE_19] [RULE_18]
        end
    end

    // =========================================
    // reply status held for transmit flags
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            resp_reg <= STAT_WAKE;
            resp_ok_reg <= 1'b0;
            done_seen_reg <= 1'b0;
        end else if (state_reg == ST_SLEEP) begin
            resp_reg <= STAT_WAKE; // [RULE_06]
            resp_ok_reg <= 1'b0;
            done_seen_reg <= 1'b0;
        end else if (state_reg == ST_WAKE) begin
            resp_ok_reg <= 1'b1; // [RULE_06]
        end else if (state_reg == ST_CMD) begin
            resp_ok_reg <= 1'b0;
            done_seen_reg <= 1'b0;
        end else if (parse_end && bad_reg) begin
            resp_reg <= STAT_COMM_ERR; // [RULE_24] [RULE_07]
            resp_ok_reg <= 1'b1;
        end else if (state_reg == ST_EXEC) begin
            if (exec_done && !done_seen_reg) begin
                done_seen_reg <= 1'b1;
                resp_reg <= exec_err ? STAT_EXEC_ERR : exec_result; // [RULE_24]
            end
            if (exec_end) begin
                resp_ok_reg <= 1'b1; // [RULE_08]
            end
        end
    end

    // =========================================
    // reply block into the buffer
    assign resp_crc = auth_crc_byte(auth_crc_byte(CRC_INIT, RESP_COUNT), resp_reg); // [RULE_04]
    assign buf_in_valid = (state_reg == ST_TX) && (tx_idx_reg != RESP_LAST);

    always_comb begin
        case (tx_idx_reg)
            3'h0: buf_in_data = RESP_COUNT; // [RULE_24]
            3'h1: buf_in_data = resp_reg;
            3'h2: buf_in_data = resp_crc[7:0]; // [RULE_05]
            default: buf_in_data = resp_crc[15:8]; // [RULE_05]
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_idx_reg <= 3'h0;
        end else if (state_reg != ST_TX) begin
            tx_idx_reg <= 3'h0;
        end else if (buf_in_valid && buf_in_ready) begin
            tx_idx_reg <= tx_idx_reg + 3'h1;
        end
    end

    auth_buf2 #(
        .WIDTH(8)
    ) u_reply_buf (
        .clock(clock),
        .arst_n(arst_n),
        .flush(low_power_reg), // [RULE_01]
        .in_valid(buf_in_valid),
        .in_data(buf_in_data),
        .in_ready(buf_in_ready),
        .out_valid(tx_valid),
        .out_data(tx_data),
        .out_ready(tx_ready)
    );

    // =========================================
    // low power and engine reset
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            low_power_reg <= 1'b1;
        end else begin
            low_power_reg <= (state_reg == ST_SLEEP) || go_sleep; // [RULE_01]
        end
    end

    assign low_power = low_power_reg;
    assign eng_rst = low_power_reg; // [RULE_01]
    assign rx_byte = rx_reg;
    assign exec_start = exec_start_reg;

endmodule

// File: auth_io_chk.sv
// Purpose: port assertions
// Assumes: bench-sized intervals
// Notes: bound into the controller
`timescale 1ns/1ps
module auth_io_chk
#(
    parameter int BLOCK_CHECK_CYCLES = 20,
    parameter int TOKEN_GAP_CYCLES = 200,
    parameter int WATCHDOG_CYCLES = 5000,
    parameter int WAKE_CYCLES = 10
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire auth_pkg::auth_tok_t tok,
    input wire auth_pkg::auth_byte_t rx_byte,
    input wire logic exec_start,
    input wire logic exec_done,
    input wire logic eng_rst,
    input wire logic low_power,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready
);
    localparam int QUIET_MAX = TOKEN_GAP_CYCLES + WAKE_CYCLES + BLOCK_CHECK_CYCLES + 8;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // =========================================
    // helper counters
    logic busy_reg;
    logic tok_any;
    logic quiet_rst;
    int quiet_reg;
    int awake_reg;
    assign tok_any = tok.lead || tok.done;
    assign quiet_rst = low_power || busy_reg || exec_start || tx_valid
        || (tok.done && !tok.bad);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy_reg <= 1'b0;
            quiet_reg <= 0;
            awake_reg <= 0;
        end else begin
            busy_reg <= !low_power && (exec_start || (busy_reg && !exec_done));
            quiet_reg <= quiet_rst ? 0 : quiet_reg + 1;
            awake_reg <= low_power ? 0 : awake_reg + 1;
        end
    end
    // =========================================
    // sequences and assertions
    sequence s_wake;
        $fell(low_power);
    endsequence
    sequence s_quiet;
        (!rx_byte.valid && !tx_valid && !exec_start) [*8];
    endsequence
    a_pair_sleep: assert property (low_power == eng_rst)
        else $error("sleep pair differs");
    a_sleep_hold: assert property (
        low_power && !tok_any && !$past(tok_any) |=> low_power)
        else $error("woke without token");
    a_asleep_mute: assert property (low_power && $past(low_power) |->
        !tx_valid && !rx_byte.valid && !exec_start)
        else $error("active while asleep");
    a_wake_token: assert property (low_power && tok_any |-> ##[1:2] !low_power)
        else $error("token did not wake");
    a_wake_quiet: assert property (s_wake |-> s_quiet)
        else $error("output in wake delay");
    a_tx_hold: assert property (tx_valid && !tx_ready |=>
        low_power || (tx_valid && $stable(tx_data)))
        else $error("stalled reply lost");
    a_exec_busy: assert property (exec_start |->
        !tx_valid ##1 (!tx_valid && !exec_start) [*8])
        else $error("activity in execution");
    a_gap_limit: assert property (quiet_reg <= QUIET_MAX)
        else $error("gap limit missed");
    a_watchdog_cap: assert property (awake_reg <= WATCHDOG_CYCLES + 2)
        else $error("watchdog missed");
endmodule
bind auth_io_ctrl auth_io_chk #(
    .BLOCK_CHECK_CYCLES(BLOCK_CHECK_CYCLES),
    .TOKEN_GAP_CYCLES(TOKEN_GAP_CYCLES),
    .WATCHDOG_CYCLES(WATCHDOG_CYCLES),
    .WAKE_CYCLES(WAKE_CYCLES)
) u_chk (.clock, .arst_n, .tok, .rx_byte, .exec_start, .exec_done, .eng_rst, .low_power,
    .tx_valid, .tx_data, .tx_ready);

// File: auth_sys_model.sv
// Purpose: far-side engine and receiver
// Assumes: bench sets run length, result
// Notes: results garbage off done
`timescale 1ns/1ps
module auth_sys_model (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic eng_rst,
    input wire logic exec_start,
    input wire logic hold,
    input wire logic [7:0] run_len,
    input wire logic fail,
    input wire logic [7:0] answer,
    output logic exec_done,
    output logic exec_err,
    output logic [7:0] exec_result,
    output logic tx_ready
);
    logic run_reg;
    logic [7:0] cnt_reg;
    // =========================================
    // engine
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n || eng_rst) begin
            run_reg <= 1'b0;
            cnt_reg <= 8'h00;
        end else if (exec_start) begin
            run_reg <= 1'b1;
            cnt_reg <= run_len;
        end else if (run_reg && cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end else begin
            run_reg <= 1'b0;
        end
    end
    assign exec_done = run_reg && cnt_reg == 8'h00;
    assign exec_err = exec_done ? fail : !fail;
    assign exec_result = exec_done ? answer : ~answer;
    // receiver stalls as told
    assign tx_ready = !hold;
endmodule

// File: auth_chip_io_session_ctrl_tb.sv
// Purpose: session controller bench
// Assumes: decoded tokens, small intervals
// Notes: driver queues, monitor pops
`timescale 1ns/1ps
module auth_chip_io_session_ctrl_tb;
    import auth_pkg::*;
    localparam int CHK = 20;
    localparam int RUN = 30;
    localparam int GAP = 200;
    localparam int WDG = 5000;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    auth_tok_t tok = '0;
    auth_byte_t rx_byte;
    logic exec_start, exec_done, exec_err, eng_rst, low_power, tx_valid, tx_ready;
    logic [7:0] exec_result, tx_data, res;
    logic [7:0] ans = 8'h00, run_len = 8'h28;
    logic hold = 1'b0, fail = 1'b0, slept = 1'b0;
    int seed = 97229;
    int bad_count = 0, samples_checked = 0, cycles = 0, n;
    logic [7:0] exp_q[$];
    always #20 clock = ~clock;
    auth_io_ctrl #(.BLOCK_CHECK_CYCLES(CHK), .COMMAND_RUN_CYCLES(RUN), .TOKEN_GAP_CYCLES(GAP),
        .WATCHDOG_CYCLES(WDG), .WAKE_CYCLES(10)) u_dut (.clock, .arst_n, .tok, .rx_byte,
        .exec_start, .exec_done, .exec_err, .exec_result, .eng_rst, .low_power, .tx_valid,
        .tx_data, .tx_ready);
    auth_sys_model u_sys (.clock, .arst_n, .eng_rst, .exec_start, .hold, .run_len, .fail,
        .answer(ans), .exec_done, .exec_err, .exec_result, .tx_ready);
    // =========================================
    // tasks
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic put_bit(input logic v);
        tok = 4'b1000;
        step(1);
        tok = {2'b01, v, 1'b0};
        step(1);
        tok = 4'b0000;
        step(1);
    endtask
    task automatic put_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            put_bit(b[i]);
        end
    endtask
    function automatic logic [15:0] crc_of(input logic [15:0] d);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? 16'h8005 : 16'h0000);
        end
        return c;
    endfunction
    task automatic fetch(input logic [7:0] st);
        logic [15:0] c;
        c = crc_of({st, 8'h04});
        exp_q = {exp_q, 8'h04, st, c[7:0], c[15:8]};
        put_byte(FLAG_TRANSMIT);
        for (int k = 0; k < 400 && exp_q.size() != 0; k++) begin
            step(1);
        end
        cmp(8'(exp_q.size()), 8'h00);
        exp_q.delete();
    endtask
    task automatic wake;
        tok = 4'b1000;
        step(1);
        tok = 4'b0000;
        step(2);
        put_bit(1'b1);
        step(10);
    endtask
    task automatic send_cmd(input logic [7:0] cnt, input logic [7:0] x, input logic ok);
        logic [15:0] c;
        c = crc_of({x, cnt});
        put_byte(FLAG_COMMAND);
        put_byte(cnt);
        if (cnt == 8'h04) begin
            exp_q.push_back(x);
            put_byte(x);
            put_byte(c[7:0] ^ {7'h00, !ok});
            put_byte(c[15:8]);
        end
        step(CHK + 5);
    endtask
    // =========================================
    // stall and monitor
    always @(posedge clock) begin
        #1;
        hold = 1'($random(seed));
    end
    always @(posedge clock) begin
        cycles++;
        if (low_power === 1'b1) begin
            slept = 1'b1;
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            cmp(tx_data, exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX);
        end
        if (rx_byte.valid === 1'b1) begin
            cmp(rx_byte.data, exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX);
        end
        if (cycles > 20000) begin
            bad_count++;
            $display("Error at %0t: timeout", $time);
            end_sim();
        end
    end
    // =========================================
    // main sequence
    initial begin
        step(12);
        arst_n = 1'b1;
        step(2);
        wake();
        fetch(STAT_WAKE);
        put_byte(8'h5A);
        fetch(STAT_WAKE);
        $display("wake done");
        res = 8'($random(seed));
        send_cmd(8'h04, res, 1'b0);
        fetch(STAT_COMM_ERR);
        fetch(STAT_COMM_ERR);
        for (int k = 0; k < 2; k++) begin
            send_cmd(k ? 8'h28 : 8'h03, 8'h00, 1'b1);
            fetch(STAT_COMM_ERR);
        end
        $display("malformed done");
        for (int k = 0; k < 2; k++) begin
            res = 8'($random(seed));
            ans = 8'($random(seed));
            fail = k[0];
            run_len = k ? 8'h02 : 8'h28;
            send_cmd(8'h04, res, 1'b1);
            if (k == 0) begin
                put_byte(FLAG_TRANSMIT);
            end
            step(RUN + 40);
            fetch(k ? STAT_EXEC_ERR : ans);
            fetch(k ? STAT_EXEC_ERR : ans);
        end
        $display("command done");
        put_byte(FLAG_SLEEP);
        step(3);
        cmp(8'(low_power), 8'h01);
        cmp(8'(eng_rst), 8'h01);
        for (int k = 0; k < 3; k++) begin
            wake();
            if (k > 0) begin
                tok = 4'b1000;
                step(1);
                tok = (k == 2) ? 4'b0001 : 4'b0000;
                step(1);
                tok = 4'b0000;
            end
            step(GAP - 40);
            cmp(8'(low_power), 8'h00);
            for (n = 0; n < 80 && low_power !== 1'b1; n++) begin
                step(1);
            end
            cmp(8'(low_power), 8'h01);
        end
        $display("timeout done");
        wake();
        slept = 1'b0;
        n = cycles;
        while (!slept && cycles - n < WDG + 200) begin
            put_byte(8'h00);
        end
        cmp(8'(cycles - n > WDG - 60 && cycles - n < WDG + 30), 8'h01);
        step(2 * GAP);
        wake();
        fetch(STAT_WAKE);
        $display("watchdog done");
        step(5);
        end_sim();
    end
endmodule
